// ==== dosr_router.sv ====
/*
 drive output signal router: contactor control, status outputs, delayed
 outputs, fieldbus bit mapping and three analogue outputs.
 assumes drive state inputs are synchronous to clk_i except the heatsink
 temperature and dc-link words, which are slow sampled values on the same clock.
*/
// Implementation choices: strobed register access and the register offsets.
`timescale 1ns/1ns
module dosr_router #(
  parameter int unsigned PULSE_CYCLES = dosr_pkg::PULSE_CYC,
  parameter int unsigned DW = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire logic mc_need_i,
  input wire logic stopped_i,
  input wire logic stop_cmd_i,
  input wire logic start_cmd_i,
  input wire logic ready_i,
  input wire logic modulating_i,
  input wire logic fault_i,
  input wire logic warning_i,
  input wire logic quick_stop_i,
  input wire logic interlock_i,
  input wire logic ext_fault_i,
  input wire logic ref_fault_i,
  input wire logic reverse_i,
  input wire logic synced_i,
  input wire logic [15:0] heatsink_temp_i,
  input wire logic [15:0] dc_voltage_i,
  input wire logic [15:0] fieldbus_word_i,
  input wire logic [255:0] signal_words_i,
  input wire logic signed [15:0] ao_src_i [15],
  output logic main_contactor_close_o,
  output logic main_contactor_open_o,
  output logic ready_o,
  output logic run_o,
  output logic fault_o,
  output logic fault_n_o,
  output logic warning_o,
  output logic common_alarm_o,
  output logic heatsink_hot_flag_o,
  output logic charge_o,
  output logic quick_stop_active_o,
  output logic ready_for_start_o,
  output logic temp_superv_o,
  output logic [15:0] status_word_o,
  output logic delayed_output_one_o,
  output logic delayed_output_two_o,
  output logic [3:0] fieldbus_bit_valid_o,
  output logic [15:0] fieldbus_bit_target_param_o [4],
  output logic [3:0] fieldbus_bit_value_o,
  output logic [DW-1:0] ao_o [3]
);
  import dosr_pkg::*;
  // signed copy of full scale, so that negative offsets stay negative
  localparam logic signed [31:0] FULL_S = 32'(AO_FULL);

  logic [2:0] ctrl;
  logic [3:0] inv_mask;
  logic [15:0] dc_lim;
  logic [17:0] temp_sup;
  logic [15:0] do_cfg [2];
  logic [23:0] do_on [2];
  logic [23:0] do_off [2];
  logic [15:0] fb_tgt [4];
  logic [31:0] ao_cfg [3];
  logic alarm_clr;
  logic alarm_latch;
  dosr_mc_e mc_state;
  logic [$clog2(PULSE_CYCLES+1)-1:0] pulse_cnt;
  logic charging;
  logic [1:0] do_q;

  // registers: software writes steer contactor mode, masks and output selections
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= '0;
      inv_mask <= '0;
      dc_lim <= 16'hffff;
      temp_sup <= '0;
      do_cfg <= '{default: '0};
      do_on <= '{default: '0};
      do_off <= '{default: '0};
      fb_tgt <= '{default: '0};
      ao_cfg <= '{default: '0};
    end else if (wr_i) begin
      case (addr_i)
        A_CTRL: ctrl <= wdata_i[2:0];
        A_INVMASK: inv_mask <= wdata_i[3:0];
        A_DCLIM: dc_lim <= wdata_i[15:0];
        A_TEMPSUP: temp_sup <= wdata_i[17:0];
        A_DO1_CFG: do_cfg[0] <= wdata_i[15:0];
        A_DO2_CFG: do_cfg[1] <= wdata_i[15:0];
        A_DO1_ON: do_on[0] <= wdata_i[23:0];
        A_DO1_OFF: do_off[0] <= wdata_i[23:0];
        A_DO2_ON: do_on[1] <= wdata_i[23:0];
        A_DO2_OFF: do_off[1] <= wdata_i[23:0];
        A_FB_TGT: fb_tgt[wdata_i[17:16]] <= wdata_i[15:0];
        A_AO0: ao_cfg[0] <= wdata_i;
        A_AO1: ao_cfg[1] <= wdata_i;
        A_AO2: ao_cfg[2] <= wdata_i;
        default: ;
      endcase
    end
  end

  assign alarm_clr = wr_i && (addr_i == A_ALARM_CLR) && wdata_i[0];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_o <= '0;
    end else if (rd_i) begin
      case (addr_i)
        A_CTRL: rdata_o <= {29'h0, ctrl};
        A_INVMASK: rdata_o <= {28'h0, inv_mask};
        A_DCLIM: rdata_o <= {16'h0, dc_lim};
        A_TEMPSUP: rdata_o <= {14'h0, temp_sup};
        A_DO1_CFG: rdata_o <= {16'h0, do_cfg[0]};
        A_DO2_CFG: rdata_o <= {16'h0, do_cfg[1]};
        A_DO1_ON: rdata_o <= {8'h0, do_on[0]};
        A_DO1_OFF: rdata_o <= {8'h0, do_off[0]};
        A_DO2_ON: rdata_o <= {8'h0, do_on[1]};
        A_DO2_OFF: rdata_o <= {8'h0, do_off[1]};
        A_AO0: rdata_o <= ao_cfg[0];
        A_AO1: rdata_o <= ao_cfg[1];
        A_AO2: rdata_o <= ao_cfg[2];
        A_STATUS: rdata_o <= {16'h0, do_q, alarm_latch, quick_stop_active_o, charging,
                              mc_state, status_word_o[STW_DC_BIT], temp_superv_o,
                              main_contactor_open_o, main_contactor_close_o, run_o,
                              ready_o, fault_o, warning_o, heatsink_hot_flag_o};
        default: rdata_o <= '0;
      endcase
    end else begin
      rdata_o <= '0;
    end
  end

  // contactor: effective demand drops with mc_need_i, and with stop-open set also on a stop command once stopped
  logic mc_demand;
  assign mc_demand = mc_need_i && !(ctrl[C_STOP_OPEN] && stop_cmd_i && stopped_i);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mc_state <= dosr_mc_open;
      pulse_cnt <= '0;
      main_contactor_close_o <= 1'b0;
      main_contactor_open_o <= 1'b0;
    end else if (!ctrl[C_PULSE]) begin
      main_contactor_close_o <= mc_demand;
      main_contactor_open_o <= 1'b0;
      mc_state <= mc_demand ? dosr_mc_closed : dosr_mc_open;
      pulse_cnt <= '0;
    end else begin
      // pulse mode selected by the C_PULSE bit of the control register
      case (mc_state)
        dosr_mc_open: if (mc_demand) begin
          mc_state <= dosr_mc_closing;
          main_contactor_close_o <= 1'b1;
          pulse_cnt <= '0;
        end
        dosr_mc_closed: if (!mc_demand) begin
          mc_state <= dosr_mc_opening;
          main_contactor_open_o <= 1'b1;
          pulse_cnt <= '0;
        end
        dosr_mc_closing, dosr_mc_opening: begin
          if (pulse_cnt == ($bits(pulse_cnt))'(PULSE_CYCLES - 1)) begin
            main_contactor_close_o <= 1'b0;
            main_contactor_open_o <= 1'b0;
            mc_state <= (mc_state == dosr_mc_closing) ? dosr_mc_closed : dosr_mc_open;
          end else begin
            pulse_cnt <= pulse_cnt + 1'b1;
          end
        end
        default: mc_state <= dosr_mc_open;
      endcase
    end
  end

  // status outputs; set of alarm wins over a same-cycle clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      alarm_latch <= 1'b0;
      charging <= 1'b0;
    end else begin
      alarm_latch <= warning_i | (alarm_latch & ~alarm_clr);
      // charge begins on start and drops once modulating (run state)
      charging <= ctrl[C_CHARGE_EN] & start_cmd_i & ~modulating_i & ~quick_stop_i;
    end
  end

  logic temp_sup_hit;
  always_comb begin
    case (temp_sup[17:16])
      SUP_LOW: temp_sup_hit = heatsink_temp_i < temp_sup[15:0];
      SUP_HIGH: temp_sup_hit = heatsink_temp_i > temp_sup[15:0];
      default: temp_sup_hit = 1'b0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ready_o <= 1'b0;
      run_o <= 1'b0;
      fault_o <= 1'b0;
      fault_n_o <= 1'b1;
      warning_o <= 1'b0;
      common_alarm_o <= 1'b0;
      heatsink_hot_flag_o <= 1'b0;
      charge_o <= 1'b0;
      quick_stop_active_o <= 1'b0;
      ready_for_start_o <= 1'b0;
      temp_superv_o <= 1'b0;
      status_word_o <= '0;
    end else begin
      ready_o <= ready_i;
      run_o <= modulating_i;
      fault_o <= fault_i;
      fault_n_o <= ~fault_i;
      warning_o <= warning_i ^ inv_mask[1];
      common_alarm_o <= alarm_latch ^ inv_mask[0];
      heatsink_hot_flag_o <= heatsink_temp_i > TEMP_WARN_LIMIT;
      charge_o <= charging;
      quick_stop_active_o <= quick_stop_i | (quick_stop_active_o & ~start_cmd_i);
      ready_for_start_o <= ~interlock_i & ~fault_i;
      temp_superv_o <= temp_sup_hit;
      status_word_o <= '0;
      status_word_o[STW_DC_BIT] <= dc_voltage_i > dc_lim;
    end
  end

  // fieldbus bits 0..3 passed to target identifiers; 0 false, 1 true
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fieldbus_bit_valid_o <= '0;
      fieldbus_bit_value_o <= '0;
      fieldbus_bit_target_param_o <= '{default: '0};
    end else begin
      for (int i = 0; i < 4; i++) begin
        fieldbus_bit_valid_o[i] <= fb_tgt[i] != 16'h0000;
        fieldbus_bit_value_o[i] <= fieldbus_word_i[i];
        fieldbus_bit_target_param_o[i] <= fb_tgt[i];
      end
    end
  end

  // delayed outputs; cfg: [3:0] content, [11:4] word index, [15:12] bit
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_do
      logic src;
      logic q;
      logic [23:0] cnt;
      logic [7:0] widx;
      assign widx = do_cfg[g][11:4];
      assign do_q[g] = q;
      always_comb begin
        case (do_cfg[g][3:0])
          4'h1: src = ready_i;
          4'h2: src = modulating_i;
          4'h3: src = fault_i;
          4'h4: src = ~fault_i;
          4'h5: src = heatsink_hot_flag_o;
          4'h6: src = ext_fault_i;
          4'h7: src = ref_fault_i;
          4'h8: src = warning_i;
          4'h9: src = reverse_i;
          4'ha: src = synced_i;
          4'hb: src = start_cmd_i;
          4'hc: src = fieldbus_word_i[2];
          4'hd: src = fieldbus_word_i[3];
          SRC_IDBIT: src = signal_words_i[{widx[3:0], do_cfg[g][15:12]}];
          default: src = 1'b0;
        endcase
      end
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          q <= 1'b0;
          cnt <= '0;
        end else if (src == q) begin
          cnt <= '0;
        end else if (cnt >= (src ? do_on[g] : do_off[g])) begin
          q <= src;
          cnt <= '0;
        end else begin
          cnt <= cnt + 1'b1;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      delayed_output_one_o <= 1'b0;
      delayed_output_two_o <= 1'b0;
    end else begin
      delayed_output_one_o <= do_q[0] ^ inv_mask[2];
      delayed_output_two_o <= do_q[1] ^ inv_mask[3];
    end
  end

  // analogue: cfg [3:0] content, [7:4] filter shift, [8] invert, [9] min,
  // [19:10] scale percent, [31:20] signed offset in 0.1 % of full scale
  generate
    for (g = 0; g < 3; g++) begin : g_ao
      logic signed [31:0] filt;
      logic signed [31:0] raw;
      logic signed [31:0] val;
      logic signed [31:0] scl;
      logic signed [31:0] lim;
      logic [3:0] code;
      logic [DW-1:0] ao_q;
      assign code = ao_cfg[g][3:0];
      assign ao_o[g] = ao_q;
      always_comb begin
        raw = 32'(ao_src_i[code]);
        // bidirectional codes: -full..+full folded to 0..full
        if (code == AO_TQ_BI || code == AO_PW_BI || code == AO_SP_BI) begin
          raw = (raw + FULL_S) >>> 1;
        end
        // code 15 has no source; it reads as not used
        if (code == 4'h0 || code == 4'hf) begin
          raw = '0;
        end
        val = (ao_cfg[g][7:4] == 4'h0) ? raw : filt;
        scl = (val * $signed({22'h0, ao_cfg[g][19:10]})) / 32'sd100;
        scl = scl + (32'(signed'(ao_cfg[g][31:20])) * FULL_S) / 32'sd1000;
        lim = (scl < 0) ? 32'sh0 : (scl > FULL_S) ? FULL_S : scl;
        if (ao_cfg[g][8]) begin
          lim = 32'(AO_FULL) - lim;
        end
        if (ao_cfg[g][9]) begin
          lim = 32'(AO_FLOOR) + (lim * 32'(AO_FULL - AO_FLOOR)) / 32'(AO_FULL);
        end
      end
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          filt <= '0;
          ao_q <= '0;
        end else begin
          // single-pole IIR; shift stands in for the time constant
          filt <= filt + ((raw - filt) >>> ao_cfg[g][7:4]);
          ao_q <= DW'(lim);
        end
      end
    end
  endgenerate
endmodule

// ==== dosr_pkg.sv ====
/*
 drive output signal router: shared constants, content codes and register map.
 assumes a 50 MHz system clock and a plain one-cycle register port.
*/
package dosr_pkg;
  localparam int unsigned CLK_HZ = 50000000;
  localparam int unsigned PULSE_MS = 2000;
  localparam int unsigned PULSE_CYC = PULSE_MS * (CLK_HZ / 1000);
  localparam logic [15:0] TEMP_WARN_LIMIT = 16'h0046;
  localparam logic [15:0] AO_FULL = 16'h2710;
  localparam logic [15:0] AO_FLOOR = 16'h07d0;
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_INVMASK = 8'h04;
  localparam logic [7:0] A_DCLIM = 8'h08;
  localparam logic [7:0] A_TEMPSUP = 8'h0c;
  localparam logic [7:0] A_DO1_CFG = 8'h10;
  localparam logic [7:0] A_DO2_CFG = 8'h14;
  localparam logic [7:0] A_DO1_ON = 8'h18;
  localparam logic [7:0] A_DO1_OFF = 8'h1c;
  localparam logic [7:0] A_DO2_ON = 8'h20;
  localparam logic [7:0] A_DO2_OFF = 8'h24;
  localparam logic [7:0] A_FB_TGT = 8'h28;
  localparam logic [7:0] A_AO0 = 8'h30;
  localparam logic [7:0] A_AO1 = 8'h34;
  localparam logic [7:0] A_AO2 = 8'h38;
  localparam logic [7:0] A_STATUS = 8'h40;
  localparam logic [7:0] A_ALARM_CLR = 8'h44;
  localparam int unsigned C_PULSE = 0;
  localparam int unsigned C_STOP_OPEN = 1;
  localparam int unsigned C_CHARGE_EN = 2;
  localparam int unsigned STW_DC_BIT = 10;
  localparam logic [1:0] SUP_LOW = 2'h1;
  localparam logic [1:0] SUP_HIGH = 2'h2;
  localparam logic [3:0] SRC_IDBIT = 4'he;
  localparam logic [3:0] AO_TQ_BI = 4'h6;
  localparam logic [3:0] AO_PW_BI = 4'h7;
  localparam logic [3:0] AO_SP_BI = 4'he;
  typedef enum logic [1:0] {
    dosr_mc_open, dosr_mc_closing, dosr_mc_closed, dosr_mc_opening
  } dosr_mc_e;
endpackage

// ==== dosr_far_side.sv ====
/*
 far-side contactor model: closes on a close command, opens on an open command.
 assumes both commands come from the router on the same clock.
*/
`timescale 1ns/1ns
module dosr_far_side (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic close_i,
  input wire logic open_i,
  output logic closed_o
);
  // open wins so that a stuck close line cannot hide an open request
  always_ff @(posedge clk_i) begin
    if (rst_i || open_i) begin
      closed_o <= 1'b0;
    end else if (close_i) begin
      closed_o <= 1'b1;
    end
  end
endmodule

// ==== dosr_router_checker.sv ====
/*
 assertions on the router ports.
 assumes it is bound to dosr_router and sees only its ports.
*/
`timescale 1ns/1ns
module dosr_router_checker import dosr_pkg::*; #(
  parameter int unsigned PULSE_CYCLES = 10
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic mc_need_i,
  input wire logic stopped_i,
  input wire logic stop_cmd_i,
  input wire logic ready_i,
  input wire logic modulating_i,
  input wire logic quick_stop_i,
  input wire logic [15:0] heatsink_temp_i,
  input wire logic main_contactor_close_o,
  input wire logic main_contactor_open_o,
  input wire logic ready_o,
  input wire logic run_o,
  input wire logic fault_o,
  input wire logic fault_n_o,
  input wire logic heatsink_hot_flag_o,
  input wire logic quick_stop_active_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [2:0] ctrl;
  logic [31:0] cl_cnt;
  logic [31:0] op_cnt;
  // shadow of the control register, so mode-dependent checks know the mode
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= 3'h0;
    end else if (wr_i && addr_i == A_CTRL) begin
      ctrl <= wdata_i[2:0];
    end
  end
  always_ff @(posedge clk_i) begin
    cl_cnt <= (rst_i || !main_contactor_close_o) ? 32'h0 : cl_cnt + 32'h1;
    op_cnt <= (rst_i || !main_contactor_open_o) ? 32'h0 : op_cnt + 32'h1;
  end
  a_run_tracks: assert property (!$past(rst_i) |-> run_o == $past(modulating_i))
    else $error("run output off its source");
  a_ready_tracks: assert property (!$past(rst_i) |-> ready_o == $past(ready_i))
    else $error("ready output off its source");
  a_fault_pair: assert property (fault_n_o == !fault_o)
    else $error("fault outputs not complementary");
  a_hot_limit: assert property (!$past(rst_i) |->
    heatsink_hot_flag_o == ($past(heatsink_temp_i) > TEMP_WARN_LIMIT))
    else $error("heatsink flag wrong");
  a_level_close: assert property (!$past(rst_i) && $past(ctrl) == 3'h0
    && $past(ctrl, 2) == 3'h0 |-> main_contactor_close_o == $past(mc_need_i))
    else $error("level close not following need");
  a_stop_opens: assert property (!$past(rst_i) && $past(ctrl) == 3'h2
    && $past(ctrl, 2) == 3'h2 && $past(stop_cmd_i && stopped_i) |-> !main_contactor_close_o)
    else $error("contactor held closed after stop");
  a_close_pulse: assert property ($past(ctrl[0]) && $fell(main_contactor_close_o)
    |-> cl_cnt == PULSE_CYCLES)
    else $error("close pulse length wrong");
  a_open_pulse: assert property ($past(ctrl[0]) && $fell(main_contactor_open_o)
    |-> op_cnt == PULSE_CYCLES)
    else $error("open pulse length wrong");
  a_qs_active: assert property (!$past(rst_i) && $past(quick_stop_i)
    |-> quick_stop_active_o)
    else $error("quick stop not flagged");
  a_read_idle: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
    else $error("read data outside read slot");
endmodule
bind dosr_router dosr_router_checker #(.PULSE_CYCLES(PULSE_CYCLES)) i_chk (.*);

// ==== dosr_router_test.sv ====
/*
 self-checking bench for the router with a contactor model on the far side.
 assumes the checker is bound in; pulse length shortened to 10 cycles.
*/
`timescale 1ns/1ns
module dosr_router_test;
  import dosr_pkg::*;
  localparam int unsigned PULSE_CYCLES = 10;
  logic clk_i, rst_i, wr_i, rd_i, mc_need_i, stopped_i, stop_cmd_i, start_cmd_i, ready_i;
  logic modulating_i, fault_i, warning_i, quick_stop_i, interlock_i, ext_fault_i;
  logic ref_fault_i, reverse_i, synced_i, mc_closed;
  logic main_contactor_close_o, main_contactor_open_o, ready_o, run_o, fault_o, fault_n_o;
  logic warning_o, common_alarm_o, heatsink_hot_flag_o, charge_o, quick_stop_active_o;
  logic ready_for_start_o, temp_superv_o, delayed_output_one_o, delayed_output_two_o;
  logic [7:0] addr_i;
  logic [31:0] wdata_i, rdata_o, r;
  logic [15:0] heatsink_temp_i, dc_voltage_i, fieldbus_word_i, status_word_o;
  logic [255:0] signal_words_i;
  logic signed [15:0] ao_src_i [15];
  logic [3:0] fieldbus_bit_valid_o, fieldbus_bit_value_o;
  logic [15:0] fieldbus_bit_target_param_o [4];
  logic [15:0] ao_o [3];
  logic [31:0] ao_cfg [6] = '{32'h19001, 32'h19101, 32'h19006, 32'h19200, 32'h06419000,
    32'hf9c19001};
  logic [15:0] ao_exp [6] = '{16'd6000, 16'd4000, 16'd5000, 16'd2000, 16'd1000, 16'd5000};
  logic qs_exp = 1'b0;
  int bad_count, total_checks, cycles, n;
  int seed = 32'hf2f9e2d9;
  dosr_router #(.PULSE_CYCLES(PULSE_CYCLES)) i_dut (.*);
  dosr_far_side i_far (.clk_i(clk_i), .rst_i(rst_i), .close_i(main_contactor_close_o),
    .open_i(main_contactor_open_o), .closed_o(mc_closed));
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      stop_test();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clk_i);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 chk(rdata_o, e);
  endtask
  task automatic pulse_len(input logic sel);
    int k;
    k = 0;
    repeat (40) begin
      tick(1);
      if ((sel ? main_contactor_open_o : main_contactor_close_o) === 1'b1) k++;
    end
    chk(k, PULSE_CYCLES);
  endtask
  // cycles until delayed output one reaches lv: the delay, then one for the output register
  task automatic do_delay(input logic lv, input int d);
    int k;
    k = 0;
    while (delayed_output_one_o !== lv && k < 30) begin
      tick(1);
      k++;
    end
    chk(k, d + 1);
  endtask
  function automatic logic exp_src(input logic [3:0] c);
    case (c)
      4'h1: return ready_i;
      4'h2: return modulating_i;
      4'h3: return fault_i;
      4'h4: return !fault_i;
      4'h5: return heatsink_temp_i > TEMP_WARN_LIMIT;
      4'h6: return ext_fault_i;
      4'h7: return ref_fault_i;
      4'h8: return warning_i;
      4'h9: return reverse_i;
      4'ha: return synced_i;
      4'hb: return start_cmd_i;
      4'hc: return fieldbus_word_i[2];
      4'hd: return fieldbus_word_i[3];
      4'he: return signal_words_i[3*16+5];
      default: return 1'b0;
    endcase
  endfunction
  task automatic quiet();
    @(posedge clk_i);
    {ready_i, modulating_i, fault_i, warning_i, reverse_i, synced_i, ext_fault_i} <= 7'h0;
    {ref_fault_i, start_cmd_i, quick_stop_i, stop_cmd_i, stopped_i, mc_need_i} <= 6'h0;
  endtask
  initial begin
    {wr_i, rd_i, interlock_i, addr_i, wdata_i} = '0;
    dc_voltage_i = 16'h0;
    fieldbus_word_i = 16'h0;
    heatsink_temp_i = 16'h0;
    signal_words_i = {8{$random(seed)}};
    for (int i = 0; i < 15; i++) ao_src_i[i] = 16'(($random(seed)) & 16'h1fff);
    ao_src_i[1] = 16'sd6000;
    ao_src_i[6] = 16'sd0;
    ao_src_i[0] = 16'sd0;
    rst_i = 1'b1;
    quiet();
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    tick(1);
    chk({fault_o, fault_n_o, run_o}, 3'b010);
    rd(A_DCLIM, 32'hffff);
    rd(8'h3c, 32'h0);
    rd(A_STATUS, 32'h0);
    for (int c = 0; c < 15; c++) begin
      r = $random(seed);
      @(posedge clk_i);
      {ready_i, modulating_i, fault_i, warning_i, reverse_i, synced_i, ext_fault_i} <= r[6:0];
      {ref_fault_i, start_cmd_i, quick_stop_i, interlock_i, stop_cmd_i, stopped_i} <= r[12:7];
      heatsink_temp_i <= {12'h004, r[19:16]};
      fieldbus_word_i <= r[31:16];
      qs_exp = r[10] | (qs_exp & ~r[11]);
      wr(A_DO1_CFG, {16'h0, 4'h5, 8'h03, 4'(c)});
      wr(A_DO2_CFG, {16'h0, 4'h5, 8'h03, 4'(c)});
      tick(4);
      chk({delayed_output_one_o, delayed_output_two_o}, {2{exp_src(4'(c))}});
      chk({heatsink_hot_flag_o, run_o}, {exp_src(4'h5), modulating_i});
      chk({ready_o, fault_o, fault_n_o}, {ready_i, fault_i, !fault_i});
      chk(warning_o, warning_i);
      chk(fieldbus_bit_value_o, fieldbus_word_i[3:0]);
      chk({ready_for_start_o, quick_stop_active_o}, {!interlock_i && !fault_i, qs_exp});
    end
    $display("test source select done");
    quiet();
    wr(A_CTRL, 32'h1);
    rd(A_CTRL, 32'h1);
    @(posedge clk_i);
    mc_need_i <= 1'b1;
    pulse_len(1'b0);
    chk(mc_closed, 1'b1);
    @(posedge clk_i);
    mc_need_i <= 1'b0;
    pulse_len(1'b1);
    chk(mc_closed, 1'b0);
    wr(A_CTRL, 32'h0);
    @(posedge clk_i);
    {mc_need_i, stop_cmd_i, stopped_i} <= 3'h7;
    tick(3);
    chk(main_contactor_close_o, 1'b1);
    wr(A_CTRL, 32'h2);
    tick(3);
    chk(main_contactor_close_o, 1'b0);
    $display("test contactor done");
    quiet();
    @(posedge clk_i);
    warning_i <= 1'b1;
    tick(2);
    warning_i <= 1'b0;
    tick(3);
    chk({warning_o, common_alarm_o}, 2'b01);
    wr(A_ALARM_CLR, 32'h1);
    wr(A_DO1_CFG, 32'h0);
    wr(A_DO2_CFG, 32'h0);
    tick(3);
    chk(common_alarm_o, 1'b0);
    wr(A_INVMASK, 32'hf);
    tick(4);
    chk({common_alarm_o, warning_o, delayed_output_one_o,
      delayed_output_two_o}, 4'hf);
    wr(A_INVMASK, 32'h0);
    $display("test alarms done");
    wr(A_DO1_CFG, 32'h2);
    wr(A_DO1_ON, 32'h4);
    wr(A_DO1_OFF, 32'h2);
    @(posedge clk_i);
    modulating_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    modulating_i <= 1'b0;
    tick(10);
    chk(delayed_output_one_o, 1'b0);
    @(posedge clk_i);
    modulating_i <= 1'b1;
    tick(1);
    do_delay(1'b1, 4);
    @(posedge clk_i);
    modulating_i <= 1'b0;
    tick(1);
    do_delay(1'b0, 2);
    $display("test delays done");
    wr(A_DCLIM, 32'd500);
    @(posedge clk_i);
    dc_voltage_i <= 16'd500;
    heatsink_temp_i <= 16'd60;
    tick(3);
    chk(status_word_o, 16'h0000);
    dc_voltage_i <= 16'd501;
    tick(3);
    chk(status_word_o, 16'h0400);
    wr(A_TEMPSUP, {14'h0, SUP_HIGH, 16'd50});
    tick(3);
    chk(temp_superv_o, 1'b1);
    wr(A_TEMPSUP, {14'h0, SUP_LOW, 16'd50});
    tick(3);
    chk(temp_superv_o, 1'b0);
    wr(A_FB_TGT, {14'h0, 2'h1, 16'd416});
    tick(2);
    chk(fieldbus_bit_target_param_o[1], 16'd416);
    chk(fieldbus_bit_valid_o, 4'b0010);
    wr(A_CTRL, 32'h4);
    @(posedge clk_i);
    start_cmd_i <= 1'b1;
    n = 0;
    while (charge_o !== 1'b1 && n < 8) begin
      tick(1);
      n++;
    end
    chk(charge_o, 1'b1);
    @(posedge clk_i);
    modulating_i <= 1'b1;
    tick(3);
    chk(charge_o, 1'b0);
    $display("test supervision done");
    for (int i = 0; i < 18; i++) begin
      wr(A_AO0 + 8'(4 * (i % 3)), ao_cfg[i / 3]);
      tick(6);
      chk(ao_o[i % 3], ao_exp[i / 3]);
    end
    wr(A_AO0, 32'h19000);
    tick(4);
    wr(A_AO0, 32'h19041);
    tick(3);
    chk(ao_o[0] < 16'd6000, 1);
    $display("test analogue done");
    stop_test();
  end
endmodule
